// file: aer_uncorr_regs.sv
`timescale 1ns/100ps
module aer_uncorr_regs
	import aer_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic hot_reset_i,
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic [aer_pkg::AER_ADDR_WIDTH-1:0] cfg_addr_i,
	input wire logic [aer_pkg::AER_BE_WIDTH-1:0] cfg_be_i,
	input wire logic [aer_pkg::AER_REG_WIDTH-1:0] cfg_wdata_i,
	output logic cfg_ack_o,
	output logic cfg_hit_o,
	output logic [aer_pkg::AER_REG_WIDTH-1:0] cfg_rdata_o,
	input wire logic training_err_i,
	input wire logic dl_protocol_err_i,
	input wire logic poisoned_rx_i,
	input wire logic poisoned_tx_i,
	input wire logic fc_protocol_err_i,
	input wire logic cpl_timeout_i,
	input wire logic completer_abort_i,
	input wire logic unexp_cpl_i,
	input wire logic rx_overflow_i,
	input wire logic malformed_tlp_i,
	input wire logic ecrc_err_i,
	input wire logic unsupported_req_i,
	output logic [aer_pkg::AER_REG_WIDTH-1:0] report_vec_o,
	output logic log_header_o,
	output logic err_msg_o,
	output logic [aer_pkg::AER_REG_WIDTH-1:0] flags_o,
	output logic [aer_pkg::AER_REG_WIDTH-1:0] suppress_o
);
	import aer_pkg::*;

	logic [AER_REG_WIDTH-1:0] event_vec;
	logic [AER_REG_WIDTH-1:0] flags;
	logic [AER_REG_WIDTH-1:0] suppress;
	logic [AER_REG_WIDTH-1:0] be_bits;
	logic [AER_REG_WIDTH-1:0] flags_clear;
	logic [AER_REG_WIDTH-1:0] suppress_load;
	logic [AER_REG_WIDTH-1:0] header_word;
	logic [AER_REG_WIDTH-1:0] read_mux;
	logic [AER_REG_WIDTH-1:0] reportable;
	aer_sel_e sel;
	logic wr_strobe;
	logic wr_flags;
	logic wr_suppress;
	logic ack_reg;
	logic ack_next;
	logic hit_reg;
	logic hit_next;
	logic [AER_REG_WIDTH-1:0] rdata_reg;
	logic [AER_REG_WIDTH-1:0] rdata_next;
	logic [AER_REG_WIDTH-1:0] report_reg;
	logic [AER_REG_WIDTH-1:0] report_next;
	logic any_report_reg;
	logic any_report_next;

	// Fixed capability header word
	assign header_word[AER_CAP_ID_MSB:AER_CAP_ID_LSB] = AER_CAP_ID_VALUE;
	assign header_word[AER_CAP_VER_MSB:AER_CAP_VER_LSB] = AER_CAP_VER_VALUE;
	assign header_word[AER_NEXT_PTR_MSB:AER_NEXT_PTR_LSB] = AER_NEXT_PTR_VALUE;

	// Event sources onto their flag positions; reserved positions stay zero
	always_comb
	begin
		event_vec = '0;
		event_vec[AER_BIT_TRAINING] = training_err_i;
		event_vec[AER_BIT_DL_PROTOCOL] = dl_protocol_err_i;
		event_vec[AER_BIT_POISONED] = poisoned_rx_i | poisoned_tx_i;
		event_vec[AER_BIT_FC_PROTOCOL] = fc_protocol_err_i;
		event_vec[AER_BIT_CPL_TIMEOUT] = cpl_timeout_i;
		event_vec[AER_BIT_COMPLETER_ABORT] = completer_abort_i;
		event_vec[AER_BIT_UNEXP_CPL] = unexp_cpl_i;
		event_vec[AER_BIT_RX_OVERFLOW] = rx_overflow_i;
		event_vec[AER_BIT_MALFORMED] = malformed_tlp_i;
		event_vec[AER_BIT_ECRC] = ecrc_err_i;
		event_vec[AER_BIT_UNSUPPORTED] = unsupported_req_i;
	end

	// Config access decode; dword aligned, low two address bits ignored
	assign sel = (cfg_addr_i[AER_ADDR_WIDTH-1:2] == AER_HDR_OFFSET[AER_ADDR_WIDTH-1:2]) ? AER_SEL_HDR :
		(cfg_addr_i[AER_ADDR_WIDTH-1:2] == AER_UNC_FLAGS_OFFSET[AER_ADDR_WIDTH-1:2]) ? AER_SEL_FLAGS :
		(cfg_addr_i[AER_ADDR_WIDTH-1:2] == AER_UNC_SUPPRESS_OFFSET[AER_ADDR_WIDTH-1:2]) ? AER_SEL_SUPPRESS :
		AER_SEL_NONE;
	// Unacknowledged writes during hot reset must leave sticky state alone
	assign wr_strobe = cfg_req_i & cfg_we_i & !hot_reset_i;
	assign wr_flags = wr_strobe & (sel == AER_SEL_FLAGS);
	assign wr_suppress = wr_strobe & (sel == AER_SEL_SUPPRESS);
	assign be_bits = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
	assign flags_clear = {AER_REG_WIDTH{wr_flags}} & be_bits & cfg_wdata_i;
	assign suppress_load = {AER_REG_WIDTH{wr_suppress}} & be_bits;

	// One flag and one suppress sticky cell per bit; reserved cells are constant zero
	genvar gi;
	generate
		for (gi = 0; gi < AER_REG_WIDTH; gi++)
		begin : g_bit
			aer_sticky_bit #(
				.RESET_VALUE(AER_UNC_FLAGS_RESET[gi]),
				.IMPLEMENTED(AER_UNC_IMPL_MASK[gi])
			) u_flag (
				.mclk_i(mclk_i),
				.resetn_i(resetn_i),
				.set_i(event_vec[gi]),
				.clear_i(flags_clear[gi]),
				.load_i(1'b0),
				.load_value_i(1'b0),
				.value_o(flags[gi])
			);
			aer_sticky_bit #(
				.RESET_VALUE(AER_UNC_SUPPRESS_RESET[gi]),
				.IMPLEMENTED(AER_UNC_IMPL_MASK[gi])
			) u_suppress (
				.mclk_i(mclk_i),
				.resetn_i(resetn_i),
				.set_i(1'b0),
				.clear_i(1'b0),
				.load_i(suppress_load[gi]),
				.load_value_i(cfg_wdata_i[gi]),
				.value_o(suppress[gi])
			);
		end
	endgenerate

	// Unsuppressed events go out for logging and messaging
	assign reportable = event_vec & ~suppress;

	always_comb
	begin
		case (sel)
			AER_SEL_HDR: read_mux = header_word;
			AER_SEL_FLAGS: read_mux = flags & AER_UNC_IMPL_MASK;
			AER_SEL_SUPPRESS: read_mux = suppress & AER_UNC_IMPL_MASK;
			AER_SEL_NONE: read_mux = AER_RDATA_RESET;
			default: read_mux = AER_RDATA_RESET;
		endcase
	end

	assign ack_next = cfg_req_i & !hot_reset_i;
	assign hit_next = cfg_req_i & (sel != AER_SEL_NONE) & !hot_reset_i;
	assign rdata_next = (cfg_req_i & !cfg_we_i & !hot_reset_i) ? read_mux : AER_RDATA_RESET;
	assign report_next = hot_reset_i ? AER_RDATA_RESET : reportable;
	assign any_report_next = !hot_reset_i & (|reportable);

	// Non-sticky access state; hot reset clears it but not the sticky bits
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ack_reg <= 1'b0;
			hit_reg <= 1'b0;
			rdata_reg <= AER_RDATA_RESET;
		end
		else
		begin
			ack_reg <= ack_next;
			hit_reg <= hit_next;
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			report_reg <= AER_RDATA_RESET;
			any_report_reg <= 1'b0;
		end
		else
		begin
			report_reg <= report_next;
			any_report_reg <= any_report_next;
		end
	end

	assign cfg_ack_o = ack_reg;
	assign cfg_hit_o = hit_reg;
	assign cfg_rdata_o = rdata_reg;
	assign report_vec_o = report_reg;
	// Header log and message share one trigger; severity routing lies outside
	assign log_header_o = any_report_reg;
	assign err_msg_o = any_report_reg;
	assign flags_o = flags;
	assign suppress_o = suppress;

	// Checks
	header_id_fixed_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(cfg_req_i && !cfg_we_i && !hot_reset_i && sel == AER_SEL_HDR)
		|=> cfg_rdata_o[15:0] == 16'h0001)
		else $error("capability identifier read back wrong");

	header_ver_fixed_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(cfg_req_i && !cfg_we_i && !hot_reset_i && sel == AER_SEL_HDR)
		|=> cfg_rdata_o[19:16] == 4'h1)
		else $error("capability version read back wrong");

	next_ptr_zero_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(cfg_req_i && !cfg_we_i && !hot_reset_i && sel == AER_SEL_HDR)
		|=> cfg_rdata_o[31:20] == 12'h000)
		else $error("next capability pointer not zero");

	training_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		training_err_i |=> flags_o[0])
		else $error("training flag did not set");

	training_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(flags_o[0] && !(wr_flags && cfg_be_i[0] && cfg_wdata_i[0])) |=> flags_o[0])
		else $error("training flag dropped without a clear");

	dl_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(wr_flags && cfg_be_i[0] && cfg_wdata_i[4] && !dl_protocol_err_i) |=> !flags_o[4])
		else $error("data link flag not cleared by write one");

	poisoned_tx_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(poisoned_tx_i || poisoned_rx_i) |=> flags_o[12])
		else $error("poisoned flag did not set");

	fc_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		fc_protocol_err_i |=> flags_o[13])
		else $error("flow control flag did not set");

	fc_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(wr_flags && cfg_be_i[1] && cfg_wdata_i[13] && !fc_protocol_err_i) |=> !flags_o[13])
		else $error("flow control flag not cleared by write one");

	cpl_events_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(cpl_timeout_i || completer_abort_i || unexp_cpl_i)
		|=> (flags_o[14] || !$past(cpl_timeout_i)) && (flags_o[15] || !$past(completer_abort_i))
			&& (flags_o[16] || !$past(unexp_cpl_i)))
		else $error("completion event flag did not set");

	abort_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		completer_abort_i |=> flags_o[15])
		else $error("completer abort flag did not set");

	unexp_cpl_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		unexp_cpl_i |=> flags_o[16])
		else $error("unexpected completion flag did not set");

	rx_events_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(rx_overflow_i || malformed_tlp_i || ecrc_err_i || unsupported_req_i)
		|=> (flags_o[17] || !$past(rx_overflow_i)) && (flags_o[18] || !$past(malformed_tlp_i))
			&& (flags_o[19] || !$past(ecrc_err_i)) && (flags_o[20] || !$past(unsupported_req_i)))
		else $error("receive event flag did not set");

	reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(cfg_req_i && !cfg_we_i && !hot_reset_i && sel != AER_SEL_HDR)
		|=> (cfg_rdata_o & 32'hffe0_0fee) == 32'h0000_0000)
		else $error("reserved flag or suppress bits read nonzero");

	suppress_blocks_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(suppress_o[AER_BIT_ECRC] && ecrc_err_i && !hot_reset_i) |=> !report_vec_o[19] && flags_o[19])
		else $error("suppressed event reported or flag missed");

	report_pass_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(!suppress_o[0] && training_err_i && !hot_reset_i) |=> report_vec_o[0] && log_header_o && err_msg_o)
		else $error("unsuppressed event not reported");

	suppress_write_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(wr_suppress && cfg_be_i[2]) |=> suppress_o[20:16] == $past(cfg_wdata_i[20:16]))
		else $error("suppress bits not written");

	sticky_hot_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(hot_reset_i && event_vec == '0) |=> flags_o == $past(flags_o) && suppress_o == $past(suppress_o))
		else $error("hot reset disturbed sticky bits");

	masked_still_sets_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(suppress_o[17] && rx_overflow_i) |=> flags_o[17])
		else $error("suppressed event failed to set flag");

	ack_latency_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(cfg_req_i && !hot_reset_i) |=> cfg_ack_o ##1 (!cfg_ack_o || $past(cfg_req_i)))
		else $error("config ack timing wrong");

	map_hit_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(cfg_req_i && !hot_reset_i && sel != AER_SEL_NONE) |=> cfg_ack_o && cfg_hit_o)
		else $error("mapped access not acknowledged as hit");

	clear_set_race_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_flags && cfg_wdata_i[0] && cfg_be_i[0] && training_err_i);
	header_read_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		cfg_req_i && !cfg_we_i && sel == AER_SEL_HDR);
	masked_event_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		(|(event_vec & suppress)));
	hot_reset_keep_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		hot_reset_i && (|flags));
endmodule

// file: aer_pkg.sv
package aer_pkg;
	// Byte addresses of the capability structure in extended config space
	localparam logic [11:0] AER_HDR_OFFSET = 12'h100;
	localparam logic [11:0] AER_UNC_FLAGS_OFFSET = 12'h104;
	localparam logic [11:0] AER_UNC_SUPPRESS_OFFSET = 12'h108;

	// Header fields
	localparam int AER_CAP_ID_LSB = 0;
	localparam int AER_CAP_ID_MSB = 15;
	localparam int AER_CAP_VER_LSB = 16;
	localparam int AER_CAP_VER_MSB = 19;
	localparam int AER_NEXT_PTR_LSB = 20;
	localparam int AER_NEXT_PTR_MSB = 31;
	localparam logic [15:0] AER_CAP_ID_VALUE = 16'h0001;
	localparam logic [3:0] AER_CAP_VER_VALUE = 4'h1;
	localparam logic [11:0] AER_NEXT_PTR_VALUE = 12'h000;

	// Uncorrectable event bit positions
	localparam int AER_BIT_TRAINING = 0;
	localparam int AER_BIT_DL_PROTOCOL = 4;
	localparam int AER_BIT_POISONED = 12;
	localparam int AER_BIT_FC_PROTOCOL = 13;
	localparam int AER_BIT_CPL_TIMEOUT = 14;
	localparam int AER_BIT_COMPLETER_ABORT = 15;
	localparam int AER_BIT_UNEXP_CPL = 16;
	localparam int AER_BIT_RX_OVERFLOW = 17;
	localparam int AER_BIT_MALFORMED = 18;
	localparam int AER_BIT_ECRC = 19;
	localparam int AER_BIT_UNSUPPORTED = 20;

	// Implemented bits; 3:1, 11:5 and 31:21 are reserved and read zero
	localparam logic [31:0] AER_UNC_IMPL_MASK = 32'h001f_f011;
	localparam logic [31:0] AER_UNC_FLAGS_RESET = 32'h0000_0000;
	localparam logic [31:0] AER_UNC_SUPPRESS_RESET = 32'h0000_0000;
	localparam logic [31:0] AER_RDATA_RESET = 32'h0000_0000;
	localparam int AER_REG_WIDTH = 32;
	localparam int AER_ADDR_WIDTH = 12;
	localparam int AER_BE_WIDTH = 4;
	localparam int AER_ACK_LATENCY = 1;

	typedef enum logic [1:0] {
		AER_SEL_NONE,
		AER_SEL_HDR,
		AER_SEL_FLAGS,
		AER_SEL_SUPPRESS
	} aer_sel_e;
endpackage

// file: aer_sticky_bit.sv
`timescale 1ns/100ps
module aer_sticky_bit
	import aer_pkg::*;
#(
	parameter logic RESET_VALUE = 1'b0,
	parameter logic IMPLEMENTED = 1'b1
)
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic set_i,
	input wire logic clear_i,
	input wire logic load_i,
	input wire logic load_value_i,
	output logic value_o
);
	logic value_reg;
	logic value_next;

	// Hardware set beats a same-cycle clear or load so no event is lost
	assign value_next = !IMPLEMENTED ? 1'b0 :
		set_i ? 1'b1 :
		clear_i ? 1'b0 :
		load_i ? load_value_i : value_reg;

	// Only power-on reset touches sticky state
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			value_reg <= RESET_VALUE;
		else
			value_reg <= value_next;
	end

	assign value_o = value_reg;
endmodule

// file: aer_rc_model.sv
`timescale 1ns/100ps
module aer_rc_model
	import aer_pkg::*;
(
	output logic cfg_req_o,
	output logic cfg_we_o,
	output logic [aer_pkg::AER_ADDR_WIDTH-1:0] cfg_addr_o,
	output logic [aer_pkg::AER_BE_WIDTH-1:0] cfg_be_o,
	output logic [aer_pkg::AER_REG_WIDTH-1:0] cfg_wdata_o
);
	initial
	begin
		cfg_req_o = 1'b0;
		cfg_we_o = 1'b0;
		cfg_addr_o = 12'h000;
		cfg_be_o = 4'h0;
		cfg_wdata_o = 32'h0000_0000;
	end

	// Called at the falling edge; one cycle of request is one access
	task automatic drive(input logic rq, input logic wr, input logic [11:0] a, input logic [3:0] be,
		input logic [31:0] wd);
		cfg_req_o = rq;
		if (rq)
		begin
			cfg_we_o = wr;
			cfg_addr_o = a;
			cfg_be_o = be;
			cfg_wdata_o = wd;
		end
		else
		begin
			// Idle lines flip so a stale value never looks like a live one
			cfg_we_o = ~cfg_we_o;
			cfg_addr_o = ~cfg_addr_o;
			cfg_be_o = ~cfg_be_o;
			cfg_wdata_o = ~cfg_wdata_o;
		end
	endtask
endmodule

// file: aer_uncorrectable_error_regs_test.sv
`timescale 1ns/100ps
module aer_uncorrectable_error_regs_test;
	import aer_pkg::*;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic hr = 1'b0;
	logic [11:0] ev = 12'h000;
	logic req;
	logic we;
	logic [11:0] addr;
	logic [3:0] be;
	logic [31:0] wdata;
	logic [31:0] m_flags = 32'h0000_0000;
	logic [31:0] m_sup = 32'h0000_0000;
	logic [31:0] e_rdata = 32'h0000_0000;
	logic [31:0] e_rep = 32'h0000_0000;
	logic e_ack = 1'b0;
	logic e_hit = 1'b0;
	logic [31:0] seed = 32'h3a98;
	int fails = 0;
	int check_count = 0;
	logic [11:0] addrs [4] = '{12'h100, 12'h104, 12'h108, 12'h10c};
	int pos [12] = '{AER_BIT_TRAINING, AER_BIT_DL_PROTOCOL, AER_BIT_POISONED, AER_BIT_POISONED,
		AER_BIT_FC_PROTOCOL, AER_BIT_CPL_TIMEOUT, AER_BIT_COMPLETER_ABORT, AER_BIT_UNEXP_CPL,
		AER_BIT_RX_OVERFLOW, AER_BIT_MALFORMED, AER_BIT_ECRC, AER_BIT_UNSUPPORTED};

	always #20 mclk_i = ~mclk_i;

	aer_rc_model rc (.cfg_req_o(req), .cfg_we_o(we), .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata));

	aer_uncorr_regs dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .hot_reset_i(hr), .cfg_req_i(req),
		.cfg_we_i(we), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_ack_o(), .cfg_hit_o(),
		.cfg_rdata_o(), .training_err_i(ev[0]), .dl_protocol_err_i(ev[1]), .poisoned_rx_i(ev[2]),
		.poisoned_tx_i(ev[3]), .fc_protocol_err_i(ev[4]), .cpl_timeout_i(ev[5]), .completer_abort_i(ev[6]),
		.unexp_cpl_i(ev[7]), .rx_overflow_i(ev[8]), .malformed_tlp_i(ev[9]), .ecrc_err_i(ev[10]),
		.unsupported_req_i(ev[11]), .report_vec_o(), .log_header_o(), .err_msg_o(), .flags_o(),
		.suppress_o());

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	function automatic logic [31:0] evmap(input logic [11:0] e);
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int i = 0; i < 12; i++)
			v[pos[i]] = v[pos[i]] | e[i];
		return v;
	endfunction

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("unexpected at %0t: %s mismatch", $time, what);
		end
	endtask

	task automatic check();
		chk(dut.cfg_ack_o === e_ack, "ack");
		chk(dut.cfg_hit_o === e_hit, "hit");
		chk(dut.cfg_rdata_o === e_rdata, "read data");
		chk(dut.report_vec_o === e_rep, "report");
		chk(dut.log_header_o === (|e_rep), "log");
		chk(dut.err_msg_o === (|e_rep), "message");
		chk(dut.flags_o === m_flags, "flags");
		chk(dut.suppress_o === m_sup, "suppress");
	endtask

	// One cycle: drive at the falling edge, model the rising edge, compare at the next falling edge
	task automatic step(input logic rq, input logic wr, input logic [11:0] a, input logic [3:0] b,
		input logic [31:0] wd);
		logic [31:0] lanes;
		logic [31:0] set;
		logic [11:0] sel;
		logic take;
		rc.drive(rq, wr, a, b, wd);
		@(posedge mclk_i);
		lanes = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		set = evmap(ev);
		sel = {a[11:2], 2'b00};
		take = rq && !hr;
		e_ack = take;
		e_hit = take && (sel == 12'h100 || sel == 12'h104 || sel == 12'h108);
		e_rdata = 32'h0000_0000;
		if (take && !wr && sel == 12'h100)
			e_rdata = 32'h0001_0001;
		if (take && !wr && sel == 12'h104)
			e_rdata = m_flags;
		if (take && !wr && sel == 12'h108)
			e_rdata = m_sup;
		e_rep = hr ? 32'h0000_0000 : set & ~m_sup;
		if (take && wr && sel == 12'h104)
			m_flags = m_flags & ~(wd & lanes);
		m_flags = m_flags | set;
		if (take && wr && sel == 12'h108)
			m_sup = (m_sup & ~lanes) | (wd & lanes & 32'h001f_f011);
		@(negedge mclk_i);
		check();
	endtask

	initial
	begin
		repeat (100000) @(posedge mclk_i);
		fails++;
		end_of_test();
	end

	initial
	begin
		repeat (10) @(negedge mclk_i);
		check();
		resetn_i = 1'b1;
		step(1'b1, 1'b0, 12'h100, 4'h0, 32'h0000_0000);
		step(1'b1, 1'b1, 12'h100, 4'hf, 32'hffff_ffff);
		step(1'b1, 1'b0, 12'h100, 4'h0, 32'h0000_0000);
		for (int i = 0; i < 12; i++)
		begin
			ev = 12'h001 << i;
			step(1'b0, 1'b0, 12'h000, 4'h0, 32'h0000_0000);
			ev = 12'h000;
			step(1'b1, 1'b0, 12'h104, 4'h0, 32'h0000_0000);
			step(1'b1, 1'b1, 12'h104, 4'hf, 32'hffff_ffff);
		end
		step(1'b1, 1'b1, 12'h108, 4'hf, 32'hffff_ffff);
		step(1'b1, 1'b0, 12'h108, 4'h0, 32'h0000_0000);
		ev = 12'hfff;
		step(1'b0, 1'b0, 12'h000, 4'h0, 32'h0000_0000);
		ev = 12'h000;
		step(1'b1, 1'b1, 12'h104, 4'h2, 32'hffff_ffff);
		hr = 1'b1;
		step(1'b1, 1'b1, 12'h104, 4'hf, 32'hffff_ffff);
		step(1'b1, 1'b1, 12'h108, 4'hf, 32'h0000_0000);
		hr = 1'b0;
		step(1'b1, 1'b0, 12'h104, 4'h0, 32'h0000_0000);
		step(1'b1, 1'b1, 12'h108, 4'hf, 32'h0000_0000);
		repeat (300)
		begin
			seed = xs(seed);
			ev = seed[11:0] & seed[23:12];
			hr = (seed[28:24] == 5'h00);
			seed = xs(seed);
			// Same-edge suppress write and event is left open, so avoid it
			if (seed[4] && seed[1:0] == 2'h2)
				ev = 12'h000;
			step(seed[9] | seed[10], seed[4], addrs[seed[1:0]] | {10'h000, seed[3:2]}, seed[8:5], xs(seed));
		end
		hr = 1'b0;
		ev = 12'h0ff;
		step(1'b1, 1'b1, 12'h108, 4'h1, 32'h0000_0011);
		ev = 12'h000;
		resetn_i = 1'b0;
		@(negedge mclk_i);
		m_flags = 32'h0000_0000;
		m_sup = 32'h0000_0000;
		e_ack = 1'b0;
		e_hit = 1'b0;
		e_rdata = 32'h0000_0000;
		e_rep = 32'h0000_0000;
		check();
		resetn_i = 1'b1;
		step(1'b1, 1'b0, 12'h108, 4'h0, 32'h0000_0000);
		end_of_test();
	end
endmodule
